// >>> shared/usart_hs_defines.svh
// usart_hs_defines.svh: timing ratio, default character length and reset values.
// assumes inclusion by bare name from design files.
`ifndef USART_HS_DEFINES_SVH
`define USART_HS_DEFINES_SVH
`define CLK_RATIO_MIN 4'h9
`define CHAR_LEN_DEFAULT 4'h8
`define ERR_COUNT_READ 8'h00
`define RTS_IDLE_LEVEL 1'b0
`endif

// >>> shared/usart_hs_pkg.sv
// usart_hs_pkg: types shared by the serial block and its shift receiver.
// assumes no other package.
`default_nettype none
package usart_hs_pkg;
  typedef enum logic [1:0] {MODE_NORMAL, MODE_HANDSHAKE, MODE_SPI_SLAVE,
                            MODE_ISO_T1} mode_t;
  typedef struct packed {
    logic flow_stop_command;
    logic flow_resume_command;
    logic rx_soft_reset;
    logic rx_enable;
  } command_t;
  typedef struct packed {
    logic [7:0] data;
    logic valid;
    logic overlen;
  } rx_word_t;
endpackage
`default_nettype wire

// >>> hdl/usart_shift_rx.sv
// usart_shift_rx: spi slave shift receiver on sampled pins.
// assumes pins already synchronised by the caller.
`timescale 1ns/1ps
`default_nettype none
module usart_shift_rx (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // control
  input wire logic enable,
  input wire logic [3:0] char_len,
  // sampled pins
  input wire logic sck_rise,
  input wire logic cs_active,
  input wire logic mosi,
  // result
  output var usart_hs_pkg::rx_word_t word
);
  logic [7:0] shift_reg, shift_next;
  logic [4:0] cnt_reg, cnt_next;
  logic was_cs_reg, was_cs_next;
  usart_hs_pkg::rx_word_t word_reg, word_next;

  // count bits per frame; frame end reports length check
  always_comb begin
    shift_next = shift_reg;
    cnt_next = cnt_reg;
    was_cs_next = cs_active;
    word_next = word_reg;
    word_next.valid = 1'b0;
    if (enable && cs_active && sck_rise) begin
      shift_next = {shift_reg[6:0], mosi};
      if (cnt_reg != 5'h1f) cnt_next = cnt_reg + 5'h01;
    end
    if (was_cs_reg && !cs_active) begin
      // too many bits flags an error
      word_next.valid = enable && (cnt_reg != 5'h00);
      word_next.data = shift_reg;
      word_next.overlen = cnt_reg > {1'b0, char_len};
      cnt_next = 5'h00;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      shift_reg <= 8'h00;
      cnt_reg <= 5'h00;
      was_cs_reg <= 1'b0;
      word_reg <= '0;
    end else begin
      shift_reg <= shift_next;
      cnt_reg <= cnt_next;
      was_cs_reg <= was_cs_next;
      word_reg <= word_next;
    end
  end
  assign word = word_reg;
endmodule
`default_nettype wire

// >>> hdl/usart_handshake_iso_sync_slave.sv
// usart_handshake_iso_sync_slave: flow control, spi slave error, iso state.
// assumes sys_clk at 100 MHz; pins arrive asynchronously.
// assumes commands are one-cycle pulses from logic on sys_clk.
// Functional notes
// - handshake mode: rts stays low on full
// - flow stop command drives rts high
// - flow resume command drives rts low
// - spi slave overlength frame flags error
// - after overlength, later receptions corrupted
// - iso error count always reads zero
// - t1 receiver dies after tx; reset
`timescale 1ns/1ps
`default_nettype none
`include "usart_hs_defines.svh"
module usart_handshake_iso_sync_slave (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // configuration and commands
  input wire usart_hs_pkg::mode_t mode_config_reg,
  input wire usart_hs_pkg::command_t command_reg,
  input wire logic [3:0] char_len,
  // dma side
  input wire logic dma_rx_full,
  // line pins
  input wire logic sck_pin,
  input wire logic cs_n_pin,
  input wire logic mosi_pin,
  input wire logic iso_tx_done,
  // outputs
  output logic rts_out,
  output logic spi_error,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic iso_rx_dead,
  output logic [7:0] iso_error_count_reg
);
  logic [2:0] sck_s, cs_s, mosi_s; // three-stage synchronisers
  logic sck_q_reg; // last agreed sck level
  logic sck_q_next; // agreed level, or the old one while stages differ
  logic rts_reg, rts_next; // high asks the peer to stop sending
  logic err_reg, err_next; // sticky overlength flag
  logic poison_reg, poison_next; // sticks after an overlength frame
  logic dead_reg, dead_next; // t1 receiver out of service
  logic vld_reg, vld_next; // one-cycle word strobe
  logic [7:0] data_reg, data_next; // last word handed out
  logic sck_rise; // one-cycle pulse on an agreed rising sck
  logic cs_active; // select agreed low
  usart_hs_pkg::rx_word_t word; // frame result from the shift receiver

  // t1 decode is needed by the next-state logic and by two checks
  function automatic logic t1_mode(input usart_hs_pkg::mode_t m);
    return m == usart_hs_pkg::MODE_ISO_T1;
  endfunction

  // pins: sck and select changes count when stages two and three agree
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sck_s <= 3'h0;
      cs_s <= 3'h7;
      mosi_s <= 3'h0;
      sck_q_reg <= 1'b0;
    end else begin
      sck_s <= {sck_s[1:0], sck_pin};
      cs_s <= {cs_s[1:0], cs_n_pin};
      mosi_s <= {mosi_s[1:0], mosi_pin};
      sck_q_reg <= sck_q_next;
    end
  end
  // hold the last agreed level while the stages still disagree
  assign sck_q_next = (sck_s[1] == sck_s[2]) ? sck_s[2] : sck_q_reg;
  // edge detection relies on peer clock slow enough
  assign sck_rise = (sck_s[1] == sck_s[2]) && sck_s[2] && !sck_q_reg;
  assign cs_active = (cs_s[1] == cs_s[2]) && !cs_s[2];

  usart_shift_rx u_rx (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .enable(mode_config_reg == usart_hs_pkg::MODE_SPI_SLAVE),
    .char_len(char_len),
    .sck_rise(sck_rise),
    .cs_active(cs_active),
    .mosi(mosi_s[2]),
    .word(word)
  );

  // next state for flow control, errors and receive path
  always_comb begin
    rts_next = rts_reg;
    // stop wins when both commands arrive in one cycle
    // dma full ignored in handshake mode: defect kept
    if (command_reg.flow_stop_command) rts_next = 1'b1;
    else if (command_reg.flow_resume_command)
      rts_next = `RTS_IDLE_LEVEL;
    // receive path: word, error flag and corruption state
    err_next = err_reg;
    poison_next = poison_reg;
    vld_next = 1'b0;
    data_next = data_reg;
    if (word.valid) begin
      vld_next = 1'b1;
      // later frames come out inverted once poisoned
      data_next = poison_reg ? ~word.data : word.data;
      if (word.overlen) begin
        err_next = 1'b1;
        poison_next = 1'b1;
      end
    end
    if (command_reg.rx_soft_reset && !(word.valid && word.overlen))
      err_next = 1'b0; // soft reset clears the flag, not the poison
    // t1 receiver: a finished transmission kills it and wins over reset
    dead_next = dead_reg;
    if (t1_mode(mode_config_reg) && iso_tx_done)
      dead_next = 1'b1;
    else if (command_reg.rx_soft_reset)
      dead_next = 1'b0;
  end

  // register flow, error, iso and receive state
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rts_reg <= `RTS_IDLE_LEVEL;
      err_reg <= 1'b0;
      poison_reg <= 1'b0;
      dead_reg <= 1'b0;
      vld_reg <= 1'b0;
      data_reg <= 8'h00;
      iso_error_count_reg <= `ERR_COUNT_READ;
    end else begin
      rts_reg <= rts_next;
      err_reg <= err_next;
      poison_reg <= poison_next;
      dead_reg <= dead_next;
      vld_reg <= vld_next;
      data_reg <= data_next;
      iso_error_count_reg <= `ERR_COUNT_READ;
    end
  end
  // outputs come straight from the registers
  assign rts_out = rts_reg;
  assign spi_error = err_reg;
  assign rx_valid = vld_reg;
  assign rx_data = data_reg;
  assign iso_rx_dead = dead_reg;

  // flow control: a command shows on rts one edge later
  property p_stop;
    @(posedge sys_clk) disable iff (sys_rst)
      command_reg.flow_stop_command |=> rts_out;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not high");
  // resume alone lowers rts
  property p_resume;
    @(posedge sys_clk) disable iff (sys_rst)
      (command_reg.flow_resume_command && !command_reg.flow_stop_command)
      |=> !rts_out;
  endproperty
  a_resume: assert property (p_resume) else $error("resume");
  // a filling dma buffer never raises rts in this revision
  property p_full;
    @(posedge sys_clk) disable iff (sys_rst)
      ($rose(dma_rx_full) && !command_reg.flow_stop_command && !rts_out)
      |=> !rts_out;
  endproperty
  a_full: assert property (p_full) else $error("rts rose on full");
  // an overlength frame end shows flag and word together
  sequence s_overlen_seen;
    word.valid && word.overlen;
  endsequence
  sequence s_flag_shown;
    spi_error ##0 rx_valid;
  endsequence
  property p_err;
    @(posedge sys_clk) disable iff (sys_rst)
      s_overlen_seen |=> s_flag_shown;
  endproperty
  a_err: assert property (p_err) else $error("no overlen error");
  // once poisoned, every later word comes out inverted
  property p_poison;
    @(posedge sys_clk) disable iff (sys_rst)
      (poison_reg && word.valid) |=> rx_data == ~$past(word.data);
  endproperty
  a_poison: assert property (p_poison) else $error("not corrupt");
  // the iso error count never shows anything but zero
  property p_ner;
    @(posedge sys_clk) disable iff (sys_rst) iso_error_count_reg == 8'h00;
  endproperty
  a_ner: assert property (p_ner) else $error("count not zero");
  // a t1 transmission leaves the receiver dead
  property p_dead;
    @(posedge sys_clk) disable iff (sys_rst)
      (t1_mode(mode_config_reg) && iso_tx_done)
      |=> iso_rx_dead;
  endproperty
  a_dead: assert property (p_dead) else $error("t1 not dead");
  // soft reset does not clear the corruption state
  property p_sticky;
    @(posedge sys_clk) disable iff (sys_rst)
      poison_reg |=> poison_reg [*2];
  endproperty
  a_sticky: assert property (p_sticky) else $error("poison lost");
  // soft reset revives a dead t1 receiver unless a new tx ends
  property p_revive;
    @(posedge sys_clk) disable iff (sys_rst)
      (command_reg.rx_soft_reset &&
       !(t1_mode(mode_config_reg) && iso_tx_done)) |=> !iso_rx_dead;
  endproperty
  a_revive: assert property (p_revive) else $error("t1 still dead");
  // the flag rises only on an overlength frame
  property p_clean_err;
    @(posedge sys_clk) disable iff (sys_rst)
      (!spi_error && !(word.valid && word.overlen)) |=> !spi_error;
  endproperty
  a_clean_err: assert property (p_clean_err) else $error("spurious");
  // a received word is shown for exactly one cycle
  property p_pulse;
    @(posedge sys_clk) disable iff (sys_rst) rx_valid |=> !rx_valid;
  endproperty
  a_pulse: assert property (p_pulse) else $error("valid held");
  // rts moves only on a command; a full buffer never moves it
  property p_rts_hold;
    @(posedge sys_clk) disable iff (sys_rst)
      (!command_reg.flow_stop_command && !command_reg.flow_resume_command)
      |=> $stable(rts_out);
  endproperty
  a_rts_hold: assert property (p_rts_hold) else $error("rts moved");
endmodule
`default_nettype wire

// >>> dv/spi_peer.sv
// spi_peer: behavioural spi master on the far side of the serial block.
// assumes pins are sampled after the bench clock's falling edge.
`timescale 1ns/1ps
`default_nettype none
module spi_peer (
  // bench clock
  input wire logic sys_clk,
  // line pins
  output logic sck,
  output logic cs_n,
  output logic mosi
);
  // clock stands low and select idles high outside frames
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // msb first; five cycles per half period keeps sck at sys_clk/10, just below sys_clk/9
  task automatic send(input int n, input logic [15:0] d);
    @(negedge sys_clk) cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      mosi = d[i];
      repeat (5) @(negedge sys_clk);
      sck = 1'b1;
      repeat (5) @(negedge sys_clk);
      sck = 1'b0;
    end
    cs_n = 1'b1;
    // released line shows no stale bit
    mosi = ~mosi;
  endtask
endmodule
`default_nettype wire

// >>> dv/tb_usart_handshake_iso_sync_slave.sv
// tb_usart_handshake_iso_sync_slave: self-checking bench for the block.
// assumes the design package is compiled first and spi_peer is present.
`timescale 1ns/1ps
`default_nettype none
module tb_usart_handshake_iso_sync_slave;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  usart_hs_pkg::mode_t mode = usart_hs_pkg::MODE_NORMAL;
  usart_hs_pkg::command_t cmd = '0;
  logic full = 1'b0;
  logic iso_done = 1'b0;
  logic [3:0] clen = 4'h8; // configured character length
  logic sck, cs_n, mosi, rts, err, vld, dead;
  logic [7:0] dat, cnt;
  logic [7:0] got_q[$];
  int fails = 0;
  int cmp_count = 0;
  bit bad = 0; // model: receptions corrupted after an overlong frame
  bit m_err = 0; // model of the sticky error flag
  always #5 sys_clk = ~sys_clk;
  spi_peer peer (.sys_clk(sys_clk), .sck(sck), .cs_n(cs_n), .mosi(mosi));
  usart_handshake_iso_sync_slave dut (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .mode_config_reg(mode), .command_reg(cmd),
    .char_len(clen), .dma_rx_full(full), .sck_pin(sck), .cs_n_pin(cs_n),
    .mosi_pin(mosi), .iso_tx_done(iso_done), .rts_out(rts),
    .spi_error(err), .rx_valid(vld), .rx_data(dat), .iso_rx_dead(dead),
    .iso_error_count_reg(cnt));
  // collect every received word mid-cycle, while it stands
  always @(negedge sys_clk) begin
    if (vld === 1'b1) got_q.push_back(dat);
    if (!sys_rst) chk8(cnt, 8'h00);
  end
  task automatic chk1(input logic g, input logic e, input string m);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t byte %h expected %h", $time, g, e);
    end
  endtask
  // one-cycle command pulse, output checked one edge later
  task automatic pulse(input usart_hs_pkg::command_t c);
    @(negedge sys_clk) cmd = c;
    @(negedge sys_clk) cmd = '0;
  endtask
  task automatic summarize;
    if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #200us;
    fails++;
    summarize();
  end
  initial begin
    logic [15:0] d;
    int n;
    void'($urandom(86));
    repeat (10) @(negedge sys_clk);
    sys_rst = 1'b0;
    // flow commands in both modes; buffer full never stops the peer
    for (int m = 0; m < 2; m++) begin
      mode = usart_hs_pkg::mode_t'(m);
      full = 1'b1;
      repeat (4) @(negedge sys_clk);
      chk1(rts, 1'b0, "rts high on full");
      pulse(4'h8);
      chk1(rts, 1'b1, "stop");
      full = 1'b0;
      pulse(4'hC);
      chk1(rts, 1'b1, "stop over resume");
      pulse(4'h4);
      chk1(rts, 1'b0, "resume");
    end
    // spi slave frames, two overlong, each followed by a soft reset
    mode = usart_hs_pkg::MODE_SPI_SLAVE;
    for (int i = 0; i < 6; i++) begin
      n = (i == 2) ? 9 : 8;
      clen = (i == 4) ? 4'h7 : 4'h8; // a short length makes eight too many
      d = 16'($urandom());
      peer.send(n, d);
      repeat (10) @(negedge sys_clk);
      m_err = m_err | (n > clen);
      chk1(err, m_err, "overlength flag");
      chk1(got_q.size() == 1, 1'b1, "word count");
      if (got_q.size() > 0)
        chk8(got_q[0], d[7:0] ^ (bad ? 8'hFF : 8'h00));
      got_q.delete();
      if (n > clen) begin
        bad = 1;
        pulse(4'h2);
        m_err = 0;
        chk1(err, 1'b0, "soft reset clears error");
      end
    end
    // iso t1: receiver dies after a transmission, soft reset revives it
    mode = usart_hs_pkg::MODE_ISO_T1;
    @(negedge sys_clk) iso_done = 1'b1;
    @(negedge sys_clk) iso_done = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk1(dead, 1'b1, "receiver alive after tx");
    pulse(4'h2);
    repeat (2) @(negedge sys_clk);
    chk1(dead, 1'b0, "receiver still dead");
    summarize();
  end
endmodule
`default_nettype wire
